// ### src/dmc_regs.svh
// Register offsets, field positions, reset values and timing counts for the multiply control block
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH
`define DMC_CTRL_OFF 12'h000
`define DMC_STAT_OFF 12'h004
`define DMC_EVT_OFF 12'h008
`define DMC_ACC_LO_OFF 12'h00C
`define DMC_ACC_HI_OFF 12'h010
`define DMC_ACC_LO_NIB 8
`define DMC_ACC_NIB 20
`define DMC_FRAC_COLS 8
`define DMC_CTRL_RST 32'h0000_0000
`define DMC_ACC_CYC_MS 100
`define DMC_CLK_MHZ 40
`define DMC_ACC_CYC_CLKS ((`DMC_ACC_CYC_MS) * 1000 * (`DMC_CLK_MHZ))
`define DMC_ROUND_DIGIT 4'h5
`endif

// ### src/dmc_pkg.sv
// Types shared by the multiply control block
package dmc_pkg;
    typedef enum logic [5:0] {
        DMC_IDLE  = 6'b000001,
        DMC_MULT  = 6'b000010,
        DMC_ROUND = 6'b000100,
        DMC_CLEAR = 6'b001000,
        DMC_PRINT = 6'b010000,
        DMC_LOCK  = 6'b100000
    } dmc_state_t;

    typedef struct packed {
        logic delta;
        logic hundreds;
        logic thousands;
        logic subtract_product_key;
        logic non_multiply;
        logic motor_bar;
    } dmc_keys_t;

    typedef struct packed {
        logic arm_multiply_step;
        logic multiply_pos;
        logic keyboard_repeat;
        logic lane64;
        logic lane65;
        logic lane66;
        logic neg_carriage;
    } dmc_lanes_t;
endpackage

// ### src/dmc_core.sv
// Multiply control: shift select, round and clear, lamps, delta clear, negative multiply, interlocks
`timescale 1ns/1ps
`include "dmc_regs.svh"
module dmc_core #(
    parameter int ACC_CYC_CLKS = `DMC_ACC_CYC_CLKS,
    parameter int NIB = `DMC_ACC_NIB
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operator pins, asynchronous
    input wire logic [5:0] keys_pin,
    input wire logic lever_rear_pin,
    input wire logic carriage_still_pin,
    input wire logic [6:0] lanes_pin,
    // Mechanism side
    output logic [2:0] lamp_sel,
    output logic neg_lamp,
    output logic print_red,
    output logic print_clear_symbol,
    output logic [1:0] print_col12_letter,
    output logic machine_cycle,
    output logic machine_locked,
    output logic selector_locked,
    output logic repeat_disable,
    output logic multiply_busy
);
    // Two-flop synchronisers for all pins
    logic [15:0] pin_s1_r, pin_s2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 16'h0000;
            pin_s2_r <= 16'h0000;
        end else begin
            pin_s1_r <= {carriage_still_pin, lever_rear_pin, lanes_pin, keys_pin};
            pin_s2_r <= pin_s1_r;
        end
    end
    dmc_pkg::dmc_keys_t keys;
    dmc_pkg::dmc_lanes_t lanes;
    logic lever_rear, still;
    assign keys = dmc_pkg::dmc_keys_t'(pin_s2_r[5:0]);
    assign lanes = dmc_pkg::dmc_lanes_t'(pin_s2_r[12:6]);
    assign lever_rear = pin_s2_r[13];
    assign still = pin_s2_r[14];

    // Key and lane rising edges, taken from second stage only
    logic [12:0] prev_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 13'h0000;
        end else begin
            prev_r <= pin_s2_r[12:0];
        end
    end
    logic [12:0] rise;
    assign rise = pin_s2_r[12:0] & ~prev_r;
    logic delta_p, nonx_p, negk_p, bar_p, lane66_p, mpos_p;
    assign delta_p = rise[5];
    assign negk_p = rise[2];
    assign nonx_p = rise[1];
    assign bar_p = rise[0];
    assign lane66_p = rise[7];
    assign mpos_p = rise[11];

    // Software control register
    logic [1:0] shift_code_r;
    logic [1:0] round_col_r;
    logic round_en_r, clear_en_r, frac_mode_r, sw_go_r;
    logic [11:0] lamp_pos_r;
    logic [63:0] mult_in_r;
    logic [31:0] ctrl_val;
    assign ctrl_val = {8'h00, lamp_pos_r, 4'h0, frac_mode_r, clear_en_r, round_en_r, round_col_r, shift_code_r, 1'b0};
    logic apb_wr, apb_rd;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;

    function automatic logic [31:0] dmc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] ctrl_nxt;
    assign ctrl_nxt = dmc_merge(ctrl_val, pwdata, pstrb);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_code_r <= 2'h0;
            round_col_r <= 2'h0;
            round_en_r <= 1'b0;
            clear_en_r <= 1'b0;
            frac_mode_r <= 1'b0;
            // Default lamps at 2/3, 5/6, 8/9 as column indices 2, 5, 8
            lamp_pos_r <= 12'h852;
            sw_go_r <= 1'b0;
        end else begin
            sw_go_r <= 1'b0;
            if (apb_wr && paddr == `DMC_CTRL_OFF) begin
                shift_code_r <= ctrl_nxt[2:1];
                round_col_r <= ctrl_nxt[4:3];
                round_en_r <= ctrl_nxt[5];
                clear_en_r <= ctrl_nxt[6];
                frac_mode_r <= ctrl_nxt[7];
                lamp_pos_r <= ctrl_nxt[23:12];
                sw_go_r <= ctrl_nxt[0];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_in_r <= 64'h0;
        end else if (apb_wr && paddr == `DMC_ACC_LO_OFF) begin
            mult_in_r[31:0] <= dmc_merge(mult_in_r[31:0], pwdata, pstrb);
        end else if (apb_wr && paddr == `DMC_ACC_HI_OFF) begin
            mult_in_r[63:32] <= dmc_merge(mult_in_r[63:32], pwdata, pstrb);
        end
    end

    // Arm, negative and lock state
    dmc_pkg::dmc_state_t state_r;
    logic armed_r, neg_r, lock_r, over_c_r, over_m_r;
    logic [4*NIB-1:0] acc_r;
    logic [31:0] cnt_r;
    logic routine;
    assign routine = state_r != dmc_pkg::DMC_IDLE && state_r != dmc_pkg::DMC_LOCK;
    logic done;
    assign done = state_r == dmc_pkg::DMC_PRINT && cnt_r == 32'h0;
    logic start;
    assign start = armed_r && mpos_p && !lock_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
        end else if (lanes.arm_multiply_step && bar_p && !keys.non_multiply) begin
            armed_r <= 1'b1;
        end else if (nonx_p || start || lever_rear) begin
            armed_r <= 1'b0;
        end
    end
    // Negative lamp set wins, held until done, lever rearward or non-multiply bar
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_r <= 1'b0;
        end else if ((negk_p || rise[6]) && !routine) begin
            neg_r <= 1'b1;
        end else if (done || (lever_rear && !routine) || (keys.non_multiply && bar_p && !lanes.multiply_pos)) begin
            neg_r <= 1'b0;
        end
    end
    // Bar with armed carriage in plain position locks the machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (lever_rear) begin
            lock_r <= 1'b0;
        end else if (armed_r && rise[11 - 0] == 1'b0 && bar_p && !lanes.multiply_pos && !lanes.arm_multiply_step) begin
            lock_r <= 1'b1;
        end
    end
    // Override keys latched at start, held until done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_c_r <= 1'b0;
            over_m_r <= 1'b0;
        end else if (start) begin
            over_c_r <= keys.hundreds;
            over_m_r <= keys.thousands;
        end else if (done) begin
            over_c_r <= 1'b0;
            over_m_r <= 1'b0;
        end
    end

    logic [3:0] shift_sel;
    always_comb begin
        case (shift_code_r)
            2'h0: shift_sel = 4'h2;
            2'h1: shift_sel = 4'h5;
            2'h2: shift_sel = 4'h7;
            default: shift_sel = 4'h8;
        endcase
        if (over_m_r) begin
            shift_sel = 4'h8;
        end else if (over_c_r) begin
            shift_sel = 4'h7;
        end
    end

    // Routine sequencer, one accumulator-cycle count per step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= dmc_pkg::DMC_IDLE;
            cnt_r <= 32'h0;
        end else begin
            if (cnt_r != 32'h0) begin
                cnt_r <= cnt_r - 32'h1;
            end
            case (state_r)
                dmc_pkg::DMC_IDLE: begin
                    if (lock_r) begin
                        state_r <= dmc_pkg::DMC_LOCK;
                    end else if (start || sw_go_r) begin
                        state_r <= dmc_pkg::DMC_MULT;
                        cnt_r <= 32'(ACC_CYC_CLKS - 1);
                    end else if ((delta_p && lever_rear) || (lane66_p && frac_mode_r)) begin
                        state_r <= dmc_pkg::DMC_CLEAR;
                        cnt_r <= 32'(ACC_CYC_CLKS - 1);
                    end
                end
                dmc_pkg::DMC_MULT: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= dmc_pkg::DMC_ROUND;
                        cnt_r <= 32'(ACC_CYC_CLKS - 1);
                    end
                end
                dmc_pkg::DMC_ROUND: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= dmc_pkg::DMC_PRINT;
                        cnt_r <= 32'(ACC_CYC_CLKS - 1);
                    end
                end
                dmc_pkg::DMC_CLEAR: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= dmc_pkg::DMC_IDLE;
                    end
                end
                dmc_pkg::DMC_PRINT: begin
                    if (cnt_r == 32'h0) begin
                        state_r <= dmc_pkg::DMC_IDLE;
                    end
                end
                dmc_pkg::DMC_LOCK: begin
                    if (!lock_r) begin
                        state_r <= dmc_pkg::DMC_IDLE;
                    end
                end
                default: state_r <= dmc_pkg::DMC_IDLE;
            endcase
        end
    end

    // Accumulator: twenty BCD nibbles, loaded shifted, then rounded and cleared
    logic [4*NIB-1:0] acc_round;
    always_comb begin
        logic [4:0] s;
        logic cy;
        s = 5'h00;
        acc_round = acc_r;
        cy = 1'b0;
        for (int i = 0; i < NIB; i++) begin
            s = {1'b0, acc_r[4*i +: 4]} + {4'h0, cy};
            if (round_en_r && i == int'(round_col_r)) begin
                s = s + {1'b0, `DMC_ROUND_DIGIT};
            end
            cy = s > 5'd9;
            acc_round[4*i +: 4] = cy ? 4'(s - 5'd10) : s[3:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
        end else if (state_r == dmc_pkg::DMC_IDLE && (start || sw_go_r)) begin
            acc_r <= (4*NIB)'(frac_mode_r ? acc_r[4*`DMC_FRAC_COLS-1:0] : 32'h0) |
                     ((4*NIB)'(mult_in_r) << (4 * shift_sel));
        end else if (state_r == dmc_pkg::DMC_ROUND && cnt_r == 32'h0) begin
            for (int i = 0; i < NIB; i++) begin
                if ((round_en_r || clear_en_r) && !frac_mode_r && i <= int'(round_col_r)) begin
                    acc_r[4*i +: 4] <= 4'h0;
                end else begin
                    acc_r[4*i +: 4] <= acc_round[4*i +: 4];
                end
            end
        // Delta clear zeros all, nothing transferred
        end else if (state_r == dmc_pkg::DMC_CLEAR && cnt_r == 32'h0) begin
            acc_r <= '0;
        end
    end

    // One lamp, only when still and lever forward
    // Lamp chosen by lane65, else lane64, else the right lamp; lamp_pos_r does not steer it
    always_comb begin
        lamp_sel = 3'b000;
        if (still && !lever_rear) begin
            if (lanes.lane65) begin
                lamp_sel = 3'b100;
            end else if (lanes.lane64) begin
                lamp_sel = 3'b010;
            end else begin
                lamp_sel = 3'b001;
            end
        end
    end

    // Mechanism outputs from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            machine_cycle <= 1'b0;
            print_red <= 1'b0;
            print_clear_symbol <= 1'b0;
            print_col12_letter <= 2'h0;
        end else begin
            // Cycle at routine end, or on bar when idle, unlocked and unarmed; delta forward as bar two
            machine_cycle <= done || (!routine && !lock_r && !armed_r && (bar_p || (delta_p && !lever_rear)));
            print_red <= done && neg_r;
            print_clear_symbol <= state_r == dmc_pkg::DMC_CLEAR && cnt_r == 32'h0;
            print_col12_letter <= done ? {over_m_r, over_c_r & ~over_m_r} : 2'h0;
        end
    end
    assign neg_lamp = neg_r;
    assign machine_locked = lock_r;
    // Selectors locked from start until product cycle done
    assign selector_locked = routine || start;
    assign repeat_disable = keys.non_multiply;
    assign multiply_busy = routine;

    // APB read side, zero wait
    assign pready = 1'b1;
    logic known;
    assign known = paddr == `DMC_CTRL_OFF || paddr == `DMC_STAT_OFF || paddr == `DMC_EVT_OFF ||
                   paddr == `DMC_ACC_LO_OFF || paddr == `DMC_ACC_HI_OFF;
    assign pslverr = psel && penable && !known;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `DMC_CTRL_OFF) begin
                prdata <= ctrl_val;
            end else if (paddr == `DMC_STAT_OFF) begin
                prdata <= {16'h0, 2'h0, state_r, lamp_sel, neg_r, lock_r, armed_r, over_m_r, over_c_r};
            end else if (paddr == `DMC_EVT_OFF) begin
                prdata <= {28'h0, shift_sel};
            end else if (paddr == `DMC_ACC_LO_OFF) begin
                prdata <= acc_r[31:0];
            end else if (paddr == `DMC_ACC_HI_OFF) begin
                prdata <= acc_r[63:32];
            end else begin
                prdata <= 32'h0;
            end
        end
    end
endmodule

// ### tb/dmc_core_assertions.sv
// Port-level property checks for the multiply control block
`timescale 1ns/1ps
module dmc_core_assertions #(
    parameter int ACC_CYC_CLKS = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Operator pins
    input wire logic [5:0] keys_pin,
    input wire logic lever_rear_pin,
    input wire logic carriage_still_pin,
    input wire logic [6:0] lanes_pin,
    // Mechanism side
    input wire logic [2:0] lamp_sel,
    input wire logic neg_lamp,
    input wire logic print_red,
    input wire logic print_clear_symbol,
    input wire logic machine_cycle,
    input wire logic selector_locked,
    input wire logic repeat_disable,
    input wire logic multiply_busy
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    int busy_cnt;
    // Run length of the routine, bounded above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= multiply_busy ? busy_cnt + 1 : 0;
        end
    end
    // Pins held long enough to pass the synchronizers
    sequence s_fwd4;
        (!lever_rear_pin && carriage_still_pin) [*4];
    endsequence
    a_lamp_left: assert property ((s_fwd4 and lanes_pin[2] [*4]) |-> lamp_sel == 3'h4)
        else $error("left lamp not lit alone");
    a_lamp_centre: assert property ((s_fwd4 and (lanes_pin[3] && !lanes_pin[2]) [*4]) |-> lamp_sel == 3'h2)
        else $error("centre lamp not lit alone");
    a_lamp_right: assert property ((s_fwd4 and (!lanes_pin[3] && !lanes_pin[2]) [*4]) |-> lamp_sel == 3'h1)
        else $error("right lamp not lit alone");
    a_lamp_rear: assert property (lever_rear_pin [*4] |-> lamp_sel == 3'h0)
        else $error("lamp lit with lever rearward");
    a_red_needs_neg: assert property (print_red |-> neg_lamp || $past(neg_lamp))
        else $error("red print without negative multiply");
    a_busy_locks: assert property (multiply_busy |-> selector_locked)
        else $error("selectors free during routine");
    a_block_cycle: assert property (multiply_busy |-> !machine_cycle)
        else $error("machine cycle during routine");
    a_busy_bound: assert property (busy_cnt <= 3 * ACC_CYC_CLKS + 2)
        else $error("routine runs too long");
    a_rep_disable: assert property (keys_pin[1] [*4] |-> repeat_disable)
        else $error("repeat not disabled");
    a_clear_pulse: assert property (print_clear_symbol |=> !print_clear_symbol)
        else $error("clear symbol longer than one cycle");
    a_neg_set: assert property ($rose(keys_pin[2]) && !lever_rear_pin |-> ##[1:6] neg_lamp)
        else $error("negative lamp not lit");
endmodule
bind dmc_core dmc_core_assertions #(.ACC_CYC_CLKS(ACC_CYC_CLKS)) u_dmc_chk (
    .pclk(pclk), .presetn(presetn), .keys_pin(keys_pin), .lever_rear_pin(lever_rear_pin),
    .carriage_still_pin(carriage_still_pin), .lanes_pin(lanes_pin), .lamp_sel(lamp_sel),
    .neg_lamp(neg_lamp), .print_red(print_red), .print_clear_symbol(print_clear_symbol),
    .machine_cycle(machine_cycle), .selector_locked(selector_locked),
    .repeat_disable(repeat_disable), .multiply_busy(multiply_busy)
);

// ### tb/dmc_operator.sv
// Operator keyboard, lever and program lane model
`timescale 1ns/1ps
module dmc_operator (
    // Clock
    input wire logic pclk,
    // Pins toward the block
    output logic [5:0] keys_pin,
    output logic lever_rear_pin,
    output logic carriage_still_pin,
    output logic [6:0] lanes_pin
);
    dmc_pkg::dmc_keys_t k = '0;
    dmc_pkg::dmc_lanes_t l = '0;
    assign keys_pin = k;
    assign lanes_pin = l;
    initial begin
        lever_rear_pin = 1'b0;
        carriage_still_pin = 1'b1;
    end
    // Slow levels, so let the synchronizers catch up
    task automatic settle();
        repeat (5) @(posedge pclk);
    endtask
    task automatic keys(input dmc_pkg::dmc_keys_t v);
        @(posedge pclk);
        k <= v;
        settle();
    endtask
    task automatic lanes(input dmc_pkg::dmc_lanes_t v);
        @(posedge pclk);
        l <= v;
        settle();
    endtask
    task automatic pos(input logic rear, input logic still);
        @(posedge pclk);
        lever_rear_pin <= rear;
        carriage_still_pin <= still;
        settle();
    endtask
    task automatic override(input logic hund);
        @(posedge pclk);
        k.hundreds <= hund;
        k.thousands <= !hund;
        l.keyboard_repeat <= 1'b1;
        settle();
    endtask
    task automatic lever_blip();
        pos(1'b1, 1'b1);
        pos(1'b0, 1'b1);
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the multiply control block
`timescale 1ns/1ps
module tb_top;
    localparam int ACC = 4;
    localparam logic [31:0] LP = 32'h0085_2000;
    localparam logic [31:0] SH [4] = '{32'h2, 32'h5, 32'h7, 32'h8};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [5:0] keys_pin;
    logic [6:0] lanes_pin;
    logic lever_rear_pin, carriage_still_pin;
    logic [2:0] lamp_sel;
    logic [3:0] stb;
    logic [1:0] let_pin, last_let;
    logic neg_lamp, print_red, print_clear_symbol, machine_cycle;
    logic machine_locked, selector_locked, repeat_disable, multiply_busy;
    int fails = 0;
    int cmp_count = 0;
    int n_red = 0;
    int n_clr = 0;
    int n_mc = 0;
    int n, m;
    dmc_core #(.ACC_CYC_CLKS(ACC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(stb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .keys_pin(keys_pin), .lever_rear_pin(lever_rear_pin),
        .carriage_still_pin(carriage_still_pin), .lanes_pin(lanes_pin), .lamp_sel(lamp_sel),
        .neg_lamp(neg_lamp), .print_red(print_red), .print_clear_symbol(print_clear_symbol),
        .print_col12_letter(let_pin), .machine_cycle(machine_cycle), .machine_locked(machine_locked),
        .selector_locked(selector_locked), .repeat_disable(repeat_disable), .multiply_busy(multiply_busy));
    dmc_operator op (.pclk(pclk), .keys_pin(keys_pin), .lever_rear_pin(lever_rear_pin),
        .carriage_still_pin(carriage_still_pin), .lanes_pin(lanes_pin));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Pulses are one cycle, so count them as they pass
    always @(posedge pclk) begin
        if (print_red === 1'b1) n_red <= n_red + 1;
        if (print_clear_symbol === 1'b1) n_clr <= n_clr + 1;
        if (machine_cycle === 1'b1) n_mc <= n_mc + 1;
        if (let_pin !== 2'b00) last_let <= let_pin;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_mc(input int lim, output int c);
        int base;
        base = n_mc;
        c = 0;
        while (n_mc == base && c < lim) begin
            @(posedge pclk);
            c++;
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        stb = 4'hF;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        op.settle();
        apb(1'b0, 12'h000, 32'h0, q, err);
        chk(32'(q[23:12]), 32'h852);
        for (int i = 0; i < 4; i++) begin
            op.lanes(7'(i << 2));
            chk(32'(lamp_sel), i[0] ? 32'h4 : i[1] ? 32'h2 : 32'h1);
        end
        op.pos(1'b1, 1'b1);
        chk(32'(lamp_sel), 32'h0);
        op.pos(1'b0, 1'b0);
        chk(32'(lamp_sel), 32'h0);
        op.pos(1'b0, 1'b1);
        op.lanes(7'h00);
        $display("test lamps done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, LP | 32'(i << 1), q, err);
            apb(1'b0, 12'h008, 32'h0, q, err);
            chk(q, SH[i]);
        end
        $display("test shifts done");
        for (int i = 0; i < 2; i++) begin
            m = n_mc;
            if (i == 0) begin
                op.keys(6'h04);
                op.keys(6'h00);
            end
            chk(32'(neg_lamp), 32'(i == 0));
            chk(n_mc, m);
            op.override(i == 0);
            apb(1'b1, 12'h000, LP | 32'h2, q, err);
            // Pre-multiply position arms on the bar, multiply position starts it
            op.lanes(7'h50);
            op.keys(i == 0 ? 6'h11 : 6'h09);
            op.keys(i == 0 ? 6'h10 : 6'h08);
            m = n_mc;
            op.lanes(7'h30);
            apb(1'b0, 12'h008, 32'h0, q, err);
            chk(q, i == 0 ? 32'h7 : 32'h8);
            chk(32'({multiply_busy, selector_locked}), 32'h3);
            chk(n_mc, m);
            wait_mc(3 * ACC + 20, n);
            chk(32'(n >= 3 * ACC - 4 && n <= 3 * ACC + 4), 32'h1);
            chk(32'(last_let), i == 0 ? 32'h1 : 32'h2);
            chk(n_red, 1);
            chk(32'(neg_lamp), 32'h0);
            op.keys(6'h00);
            op.lanes(7'h00);
        end
        $display("test routine done");
        op.lanes(7'h01);
        op.lanes(7'h00);
        chk(32'(neg_lamp), 32'h1);
        op.lever_blip();
        chk(32'(neg_lamp), 32'h0);
        m = n_mc;
        op.keys(6'h02);
        chk(32'(repeat_disable), 32'h1);
        op.keys(6'h00);
        chk(32'(repeat_disable), 32'h0);
        chk(n_mc, m);
        op.keys(6'h04);
        op.keys(6'h00);
        op.lanes(7'h40);
        op.keys(6'h03);
        chk(32'(neg_lamp), 32'h0);
        chk(n_mc, m + 1);
        op.keys(6'h00);
        op.lanes(7'h20);
        chk(32'(multiply_busy), 32'h0);
        op.lanes(7'h40);
        op.keys(6'h01);
        op.keys(6'h00);
        op.lanes(7'h00);
        m = n_mc;
        op.keys(6'h01);
        apb(1'b0, 12'h004, 32'h0, q, err);
        chk(32'(q[3]), 32'h1);
        chk(32'(machine_locked), 32'h1);
        chk(n_mc, m);
        op.keys(6'h00);
        op.lever_blip();
        chk(32'(machine_locked), 32'h0);
        $display("test cancel done");
        // Only byte zero of the multiplicand image is written
        stb <= 4'h1;
        apb(1'b1, 12'h00C, 32'hAAAA_AA57, q, err);
        stb <= 4'hF;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 12'h000, LP | (i == 0 ? 32'h31 : 32'h51), q, err);
            wait_mc(3 * ACC + 20, n);
            apb(1'b0, 12'h00C, 32'h0, q, err);
            // Five into column two carries on the first pass only, then columns two and below are cleared
            chk(q, i == 0 ? 32'h6000 : 32'h5000);
        end
        apb(1'b0, 12'h010, 32'h0, q, err);
        chk(q, 32'h0);
        $display("test round done");
        apb(1'b1, 12'h000, LP | 32'h80, q, err);
        m = n_clr;
        op.pos(1'b1, 1'b1);
        op.keys(6'h20);
        op.keys(6'h00);
        repeat (ACC + 4) @(posedge pclk);
        chk(n_clr, m + 1);
        apb(1'b0, 12'h00C, 32'h0, q, err);
        chk(q, 32'h0);
        op.pos(1'b0, 1'b1);
        n = n_mc;
        op.keys(6'h20);
        op.keys(6'h00);
        repeat (ACC + 4) @(posedge pclk);
        chk(n_clr, m + 1);
        chk(n_mc, n + 1);
        op.lanes(7'h02);
        op.lanes(7'h00);
        repeat (ACC + 4) @(posedge pclk);
        chk(n_clr, m + 2);
        $display("test delta done");
        apb(1'b0, 12'h100, 32'h0, q, err);
        chk(q, 32'h0);
        chk(32'(err), 32'h1);
        $display("test unmapped done");
        final_report();
    end
endmodule
